// ==== cssb_ctrl.v ====
/*
 * sleep, init and bus-off recovery control of a can controller.
 * assumes the protocol engine reports tx/rx activity, tx done, bit ticks,
 * received messages and bus-off entry as pclk-domain pulses and levels;
 * can_rx_pin is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
`include "cssb_map.vh"
module cssb_ctrl #(
    parameter NTX = 3,
    parameter CLK_NS = 8
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // protocol engine
    input wire can_rx_pin,
    input wire eng_tx_bit,
    input wire eng_tx_active,
    input wire eng_rx_active,
    input wire eng_bit_tick,
    input wire eng_tx_done,
    input wire eng_busoff_set,
    input wire eng_rx_msg,
    // controls toward engine and pin
    output reg can_tx_pin,
    output reg proto_clk_en,
    output reg rx_fg_load,
    output reg [NTX-1:0] tx_abort_go,
    output reg busoff_q_out
);
    localparam integer SYNC_CYC = (`CSSB_SYNC_NS + CLK_NS - 1) / CLK_NS;
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_SLEEP = 3'b100;
    reg [2:0] state_q;
    reg [7:0] ctl1_q;
    reg init_request_q, init_ack_q, sleep_request_q, busoff_hold_q, rxf_q, busoff_q;
    reg [NTX-1:0] txe_q, abtrq_q;
    reg [3:0] sync_q;
    reg [3:0] rbit_q;
    reg [7:0] occ_q;
    reg [31:0] rdata_d;
    reg rx_s1_q, rx_s2_q;
    wire wr = psel & penable & pwrite;
    wire rd = psel & ~penable & ~pwrite;
    wire asleep = state_q == ST_SLEEP;
    wire all_txe = &txe_q;
    wire busy = eng_tx_active | eng_rx_active;
    function hit;
        input [11:0] a;
        input [11:0] b;
        hit = a == b;
    endfunction
    wire mapped = hit(paddr, `CSSB_CTL0_ADDR) | hit(paddr, `CSSB_CTL1_ADDR) |
        hit(paddr, `CSSB_MISC_ADDR) | hit(paddr, `CSSB_STAT_ADDR) |
        hit(paddr, `CSSB_TXF_ADDR) | hit(paddr, `CSSB_RXF_ADDR);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= can_rx_pin;
            rx_s2_q <= rx_s1_q;
        end
    end
    // sleep state machine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RUN;
            sync_q <= 4'h0;
        end else begin
            case (state_q)
                ST_RUN: if (sleep_request_q) begin
                    state_q <= ST_WAIT;
                    sync_q <= SYNC_CYC[3:0];
                end
                ST_WAIT: if (!sleep_request_q) begin
                    state_q <= ST_RUN;
                end else if (sync_q != 4'h0) begin
                    sync_q <= sync_q - 4'h1;
                end else if (all_txe && !busy) begin
                    state_q <= ST_SLEEP;
                end
                ST_SLEEP: if (!sleep_request_q) begin
                    state_q <= ST_RUN;
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end
    // registers written by software and flags set by hardware
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_request_q <= 1'b1;
            init_ack_q <= 1'b1;
            sleep_request_q <= 1'b0;
            ctl1_q <= `CSSB_CTL1_RST;
            busoff_hold_q <= `CSSB_MISC_RST;
            txe_q <= `CSSB_TXE_RST;
            abtrq_q <= {NTX{1'b0}};
            rxf_q <= 1'b0;
        end else begin
            init_ack_q <= init_request_q & (asleep | ~sleep_request_q);
            if (wr && hit(paddr, `CSSB_CTL0_ADDR)) begin
                init_request_q <= pwdata[`CSSB_C0_INIT_REQUEST];
                sleep_request_q <= pwdata[`CSSB_C0_SLEEP_REQUEST];
            end
            if (wr && hit(paddr, `CSSB_CTL1_ADDR) && (init_ack_q || !ctl1_q[`CSSB_C1_ENABLE]))
                ctl1_q <= pwdata[7:0];
            // set beats clear: busoff entry re-arms hold
            if (eng_busoff_set)
                busoff_hold_q <= 1'b1;
            else if (wr && hit(paddr, `CSSB_MISC_ADDR) && pwdata[0])
                busoff_hold_q <= 1'b0;
            // tx empty flags cleared by one-write in sleep too
            if (wr && hit(paddr, `CSSB_TXF_ADDR)) begin
                txe_q <= (txe_q & ~pwdata[NTX-1:0]) | (eng_tx_done ? ~txe_q : {NTX{1'b0}});
                abtrq_q <= pwdata[NTX+7:8];
            end else if (eng_tx_done) begin
                txe_q <= {NTX{1'b1}};
            end
            // rx full: hardware set wins over software clear
            if (eng_rx_msg && !asleep)
                rxf_q <= 1'b1;
            else if (wr && hit(paddr, `CSSB_RXF_ADDR) && pwdata[0])
                rxf_q <= 1'b0;
        end
    end
    // bus-off recovery counter, frozen in sleep
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busoff_q <= 1'b0;
            rbit_q <= 4'h0;
            occ_q <= 8'h00;
        end else if (eng_busoff_set) begin
            busoff_q <= 1'b1;
            rbit_q <= 4'h0;
            occ_q <= 8'h00;
        end else if (busoff_q && !asleep) begin
            if (occ_q == `CSSB_OCC_NUM) begin
                if (!ctl1_q[`CSSB_C1_BUSOFF_RECOVERY_MODE] || !busoff_hold_q) begin
                    busoff_q <= 1'b0;
                    occ_q <= 8'h00;
                end
            end else if (eng_bit_tick) begin
                if (!rx_s2_q) begin
                    rbit_q <= 4'h0;
                end else if (rbit_q == `CSSB_RBIT_NUM - 1) begin
                    rbit_q <= 4'h0;
                    occ_q <= occ_q + 8'h01;
                end else begin
                    rbit_q <= rbit_q + 4'h1;
                end
            end
        end
    end
    always @* begin
        rdata_d = 32'h0;
        if (hit(paddr, `CSSB_CTL0_ADDR)) begin
            rdata_d[`CSSB_C0_INIT_REQUEST] = init_request_q;
            rdata_d[`CSSB_C0_SLEEP_REQUEST] = sleep_request_q;
        end else if (hit(paddr, `CSSB_CTL1_ADDR)) begin
            rdata_d[7:0] = ctl1_q;
            rdata_d[`CSSB_C1_SLEEP_ACK] = asleep;
            rdata_d[`CSSB_C1_INIT_ACK] = init_ack_q;
        end else if (hit(paddr, `CSSB_MISC_ADDR)) begin
            rdata_d[0] = busoff_hold_q;
        end else if (hit(paddr, `CSSB_STAT_ADDR)) begin
            rdata_d[`CSSB_ST_BUSOFF] = busoff_q;
            rdata_d[`CSSB_ST_RXACT] = eng_rx_active;
            rdata_d[`CSSB_ST_TXACT] = eng_tx_active;
            rdata_d[`CSSB_ST_SLEEP] = asleep;
            rdata_d[`CSSB_ST_RXCNT_LSB+7:`CSSB_ST_RXCNT_LSB] = occ_q;
        end else if (hit(paddr, `CSSB_TXF_ADDR)) begin
            rdata_d[NTX-1:0] = txe_q;
            rdata_d[NTX+7:8] = abtrq_q;
        end else if (hit(paddr, `CSSB_RXF_ADDR)) begin
            rdata_d[0] = rxf_q;
        end
    end
    // outputs registered; apb answers in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            can_tx_pin <= `CSSB_RECESSIVE;
            proto_clk_en <= 1'b0;
            rx_fg_load <= 1'b0;
            tx_abort_go <= {NTX{1'b0}};
            busoff_q_out <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (rd)
                prdata <= rdata_d;
            can_tx_pin <= (asleep || !ctl1_q[`CSSB_C1_ENABLE]) ? `CSSB_RECESSIVE : eng_tx_bit;
            proto_clk_en <= ctl1_q[`CSSB_C1_ENABLE] & ~asleep;
            rx_fg_load <= eng_rx_msg & ~asleep & ~rxf_q;
            tx_abort_go <= asleep ? {NTX{1'b0}} : (abtrq_q & ~txe_q);
            busoff_q_out <= busoff_q;
        end
    end
endmodule

// ==== cssb_map.vh ====
/*
 * register map, field positions, reset values and timing counts of the
 * can sleep / bus-off recovery control block.
 * assumes a 32-bit apb slave; every register takes one aligned word.
 */
// Summary of operation
// - software sets sleep_request; sleep follows a sync delay depending on bus activity.
// - pending transmit buffers are sent or aborted before sleep is entered.
// - a frame being received is finished; sleep starts when the bus next idles.
// - with no traffic, sleep is entered at once after the sync delay.
// - while asleep, sleep_request and sleep_ack both read as one.
// - sleep gates protocol clock; register access clock keeps running.
// - bus-off recovery counting of 128 x 11 recessive bits pauses during sleep.
// - can_tx_pin held recessive during sleep.
// - rx_full_flag stays readable and clearable during sleep.
// - no new message moves into rx foreground buffer while asleep.
// - tx buffers writable and empty flags clearable in sleep; no abort in sleep.
// - reconfigure: sleep, await ack, request init, await ack, write, clear init.
// - bus-off recovery automatic by default after 128 x 11 recessive bits.
// - user mode recovers once count done and busoff_hold cleared, any order.
`ifndef CSSB_MAP_VH
`define CSSB_MAP_VH
// byte offsets
`define CSSB_CTL0_ADDR 12'h000
`define CSSB_CTL1_ADDR 12'h004
`define CSSB_MISC_ADDR 12'h008
`define CSSB_STAT_ADDR 12'h00c
`define CSSB_TXF_ADDR 12'h010
`define CSSB_RXF_ADDR 12'h014
// can_control_0 fields
`define CSSB_C0_INIT_REQUEST 0
`define CSSB_C0_SLEEP_REQUEST 1
// can_control_1 fields
`define CSSB_C1_ENABLE 7
`define CSSB_C1_BUSOFF_RECOVERY_MODE 3
`define CSSB_C1_SLEEP_ACK 1
`define CSSB_C1_INIT_ACK 0
// status fields
`define CSSB_ST_BUSOFF 0
`define CSSB_ST_RXACT 1
`define CSSB_ST_TXACT 2
`define CSSB_ST_SLEEP 3
`define CSSB_ST_RXCNT_LSB 8
`define CSSB_CTL1_RST 8'h00
`define CSSB_MISC_RST 1'b1
`define CSSB_TXE_RST 3'b111
`define CSSB_RECESSIVE 1'b1
`define CSSB_OCC_NUM 128
`define CSSB_RBIT_NUM 11
`define CSSB_SYNC_NS 24
`endif

// ==== cssb_ctrl_checker.sv ====
/* port assertions for cssb_ctrl.
   assumes it is bound to cssb_ctrl with NTX handed on. */
`timescale 1ns/1ns
module cssb_ctrl_checker #(parameter NTX = 3) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // engine and pin
    input wire eng_tx_active,
    input wire eng_rx_active,
    input wire can_tx_pin,
    input wire proto_clk_en,
    input wire rx_fg_load,
    input wire [NTX-1:0] tx_abort_go,
    input wire busoff_q_out
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
answer_time_a: assert property (psel && !penable |=> pready) else $error("no ready");
ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
refuse_read_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("bad refusal");
tx_recessive_a: assert property (!proto_clk_en |-> can_tx_pin) else $error("pin dominant");
sleep_quiet_a: assert property ($fell(proto_clk_en) |-> !$past(eng_tx_active) && !$past(eng_rx_active))
    else $error("slept while busy");
no_load_a: assert property (!proto_clk_en && $past(!proto_clk_en) |-> !rx_fg_load)
    else $error("load in sleep");
no_abort_a: assert property (!proto_clk_en && $past(!proto_clk_en) |-> tx_abort_go == {NTX{1'b0}})
    else $error("abort in sleep");
busoff_freeze_a: assert property (!proto_clk_en && busoff_q_out |=> busoff_q_out)
    else $error("recovered asleep");
endmodule

// ==== cssb_bus_node.sv ====
/* other nodes on the bus, seen through the engine: bit ticks, rx pin, rx activity.
   assumes the tb raises busy to stand for a frame from another node. */
`timescale 1ns/1ns
module cssb_bus_node (
    input wire pclk,
    input wire presetn,
    input wire busy,
    output reg can_rx_pin,
    output reg eng_bit_tick,
    output reg eng_rx_active
);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        can_rx_pin <= 1'b1;
        eng_bit_tick <= 1'b0;
        eng_rx_active <= 1'b0;
    end else begin
        eng_bit_tick <= ~eng_bit_tick;
        // idle bus is pulled recessive; a frame keeps toggling so no stale level
        can_rx_pin <= busy ? ~can_rx_pin : 1'b1;
        eng_rx_active <= busy;
    end
end
endmodule

// ==== cssb_ctrl_tb_top.sv ====
/* self-checking bench for cssb_ctrl.
   assumes cssb_map.vh offsets and a 3-cycle sleep sync delay. */
`timescale 1ns/1ns
`include "cssb_map.vh"
module cssb_ctrl_tb_top;
reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, busy = 1'b0;
reg eng_tx_active = 1'b0, eng_tx_done = 1'b0, eng_busoff_set = 1'b0, eng_rx_msg = 1'b0;
// engine drives dominant so a recessive pin proves the sleep gating
reg eng_tx_bit = 1'b0;
reg [11:0] paddr = 12'h0;
reg [31:0] pwdata = 32'h0, rd;
reg err;
wire [31:0] prdata;
wire pready, pslverr, can_rx_pin, eng_bit_tick, eng_rx_active;
wire can_tx_pin, proto_clk_en, rx_fg_load, busoff_q_out;
wire [2:0] tx_abort_go;
integer num_errors = 0, checked = 0, n;
cssb_ctrl #(.NTX(3), .CLK_NS(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx_pin(can_rx_pin), .eng_tx_bit(eng_tx_bit),
    .eng_tx_active(eng_tx_active), .eng_rx_active(eng_rx_active), .eng_bit_tick(eng_bit_tick),
    .eng_tx_done(eng_tx_done), .eng_busoff_set(eng_busoff_set), .eng_rx_msg(eng_rx_msg),
    .can_tx_pin(can_tx_pin), .proto_clk_en(proto_clk_en), .rx_fg_load(rx_fg_load),
    .tx_abort_go(tx_abort_go), .busoff_q_out(busoff_q_out));
cssb_bus_node node (.pclk(pclk), .presetn(presetn), .busy(busy), .can_rx_pin(can_rx_pin),
    .eng_bit_tick(eng_bit_tick), .eng_rx_active(eng_rx_active));
initial forever #4 pclk = ~pclk;
task chk(input [31:0] got, input [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look mid-cycle where pready has settled; the edge after completes it
        @(negedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            @(negedge pclk);
            k = k + 1;
        end
        if (k >= 50)
            chk(1'b0, 1'b1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
endtask
// re-read until the bit settles; waits are bounded
task poll(input [11:0] a, input integer b, input v);
    integer k;
    begin
        k = 0;
        apb(1'b0, a, 32'h0);
        while (rd[b] !== v && k < 40) begin
            apb(1'b0, a, 32'h0);
            k = k + 1;
        end
        chk(rd[b], v);
    end
endtask
task sleep_on;
    begin
        apb(1'b1, `CSSB_CTL0_ADDR, 32'h2);
        poll(`CSSB_CTL1_ADDR, `CSSB_C1_SLEEP_ACK, 1'b1);
    end
endtask
task sleep_off;
    begin
        apb(1'b1, `CSSB_CTL0_ADDR, 32'h0);
        poll(`CSSB_CTL1_ADDR, `CSSB_C1_SLEEP_ACK, 1'b0);
        chk(proto_clk_en, 1'b1);
    end
endtask
task t_start;
    begin
        apb(1'b0, 12'h020, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b1, `CSSB_CTL1_ADDR, 32'h80);
        apb(1'b1, `CSSB_CTL0_ADDR, 32'h0);
        poll(`CSSB_CTL1_ADDR, `CSSB_C1_INIT_ACK, 1'b0);
        chk(proto_clk_en, 1'b1);
        chk(can_tx_pin, 1'b0);
        $display("test start done");
    end
endtask
task t_sleep_idle;
    begin
        sleep_on;
        apb(1'b0, `CSSB_CTL0_ADDR, 32'h0);
        chk(rd[`CSSB_C0_SLEEP_REQUEST], 1'b1);
        chk({proto_clk_en, can_tx_pin}, 2'b01);
        eng_rx_msg <= 1'b1;
        @(posedge pclk);
        eng_rx_msg <= 1'b0;
        apb(1'b0, `CSSB_RXF_ADDR, 32'h0);
        chk(rd[0], 1'b0);
        // buffer 0 launched while asleep; stays pending for the next test
        apb(1'b1, `CSSB_TXF_ADDR, 32'h1);
        apb(1'b0, `CSSB_TXF_ADDR, 32'h0);
        chk(rd[0], 1'b0);
        sleep_off;
        $display("test sleep idle done");
    end
endtask
task t_sleep_busy;
    begin
        eng_tx_active <= 1'b1;
        busy <= 1'b1;
        apb(1'b1, `CSSB_CTL0_ADDR, 32'h2);
        repeat (10) @(posedge pclk);
        apb(1'b0, `CSSB_CTL1_ADDR, 32'h0);
        chk(rd[`CSSB_C1_SLEEP_ACK], 1'b0);
        eng_tx_done <= 1'b1;
        eng_tx_active <= 1'b0;
        @(posedge pclk);
        eng_tx_done <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b0, `CSSB_CTL1_ADDR, 32'h0);
        chk(rd[`CSSB_C1_SLEEP_ACK], 1'b0);
        busy <= 1'b0;
        poll(`CSSB_CTL1_ADDR, `CSSB_C1_SLEEP_ACK, 1'b1);
        sleep_off;
        $display("test sleep busy done");
    end
endtask
task t_busoff;
    begin
        eng_busoff_set <= 1'b1;
        @(posedge pclk);
        eng_busoff_set <= 1'b0;
        // ticks every 2 cycles: 128 x 11 bits need 2816 cycles
        repeat (2000) @(posedge pclk);
        chk(busoff_q_out, 1'b1);
        n = 0;
        while (busoff_q_out !== 1'b0 && n < 2000) begin
            @(posedge pclk);
            n = n + 1;
        end
        chk(busoff_q_out, 1'b0);
        $display("test busoff done");
    end
endtask
task t_user_recovery;
    begin
        sleep_on;
        apb(1'b1, `CSSB_CTL0_ADDR, 32'h3);
        poll(`CSSB_CTL1_ADDR, `CSSB_C1_INIT_ACK, 1'b1);
        apb(1'b1, `CSSB_CTL1_ADDR, 32'h88);
        apb(1'b0, `CSSB_CTL1_ADDR, 32'h0);
        chk(rd[`CSSB_C1_BUSOFF_RECOVERY_MODE], 1'b1);
        apb(1'b1, `CSSB_CTL0_ADDR, 32'h0);
        poll(`CSSB_CTL1_ADDR, `CSSB_C1_SLEEP_ACK, 1'b0);
        eng_busoff_set <= 1'b1;
        @(posedge pclk);
        eng_busoff_set <= 1'b0;
        // count is done by now, but hold still set
        repeat (3000) @(posedge pclk);
        chk(busoff_q_out, 1'b1);
        apb(1'b1, `CSSB_MISC_ADDR, 32'h1);
        repeat (3) @(posedge pclk);
        chk(busoff_q_out, 1'b0);
        $display("test user recovery done");
    end
endtask
task close_out;
    begin
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
initial begin
    #100000;
    num_errors = num_errors + 1;
    close_out;
end
initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_start;
    t_sleep_idle;
    t_sleep_busy;
    t_busoff;
    t_user_recovery;
    close_out;
end
endmodule
bind cssb_ctrl cssb_ctrl_checker #(.NTX(NTX)) chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_tx_active(eng_tx_active), .eng_rx_active(eng_rx_active),
    .can_tx_pin(can_tx_pin), .proto_clk_en(proto_clk_en), .rx_fg_load(rx_fg_load),
    .tx_abort_go(tx_abort_go), .busoff_q_out(busoff_q_out));
